// File: bench/tb.sv
// self-checking bench for the timer load instruction group
// assumes trli_top and the decode model beside it
`timescale 1ns/1ps
`include "trli_defines.svh"
module tb;
  import trli_pkg::*;
  logic clk, rst, exec_en, done, skip_next, carry_we;
  trli_opcode_t opcode;
  trli_nibble_t acc, opnd;
  trli_byte_t t1, t2, rld1_lo, rld1_hi, rld2_lo, rld2_hi;
  trli_byte_t e1, e2, el1, eh1, el2, eh2;
  int n_errors = 0;
  int cmp_count = 0;
  // copy right after a load, plus two near-miss codes
  trli_opcode_t ops [8] = '{`TRLI_OP_LOAD_T1_LOW, `TRLI_OP_COPY_T1,
    `TRLI_OP_LOAD_T1_HIGH, `TRLI_OP_COPY_T1, `TRLI_OP_LOAD_T2_LOW,
    `TRLI_OP_LOAD_T2_HIGH, 10'h232, 10'h3FF};
  trli_decode_model dec_inst (.clk(clk), .exec_en(exec_en),
    .opcode(opcode), .acc(acc), .opnd(opnd));
  trli_top trli_top_inst (.clk(clk), .rst(rst), .exec_en(exec_en),
    .opcode(opcode), .acc(acc), .opnd(opnd), .timer1(t1), .timer2(t2),
    .timer1_low_reload(rld1_lo), .timer1_high_reload(rld1_hi),
    .timer2_low_reload(rld2_lo), .timer2_high_reload(rld2_hi), .done(done),
    .skip_next(skip_next), .carry_we(carry_we));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input trli_byte_t ex,
    input trli_byte_t got);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // the five codes of this group; any other code leaves everything alone
  function automatic logic in_group(input trli_opcode_t o);
    return o inside {`TRLI_OP_LOAD_T1_LOW, `TRLI_OP_LOAD_T1_HIGH,
      `TRLI_OP_COPY_T1, `TRLI_OP_LOAD_T2_LOW, `TRLI_OP_LOAD_T2_HIGH};
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    give_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic e, hit;
    trli_opcode_t op;
    trli_nibble_t a, b;
    rst = 1'b1;
    {e1, e2, el1, eh1, el2, eh2} = '0;
    void'($urandom(32'h2bc7));
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 300; i++) begin
      op = ops[i < 8 ? i : $urandom_range(7)];
      e = (i < 8) || ($urandom_range(9) != 0);
      a = 4'($urandom);
      b = 4'($urandom);
      dec_inst.issue(e, op, a, b);
      hit = e && in_group(op);
      if (e) begin
        case (op)
          `TRLI_OP_LOAD_T1_LOW: begin
            e1 = {b, a};
            el1 = {b, a};
          end
          `TRLI_OP_LOAD_T1_HIGH: eh1 = {b, a};
          `TRLI_OP_COPY_T1: e1 = el1;
          `TRLI_OP_LOAD_T2_LOW: begin
            e2 = {b, a};
            el2 = {b, a};
          end
          `TRLI_OP_LOAD_T2_HIGH: eh2 = {b, a};
          default: ;
        endcase
      end
      @(posedge clk);
      #1;
      chk("timer1", e1, t1);
      chk("timer1_low_reload", el1, rld1_lo);
      chk("timer1_high_reload", eh1, rld1_hi);
      chk("timer2", e2, t2);
      chk("timer2_low_reload", el2, rld2_lo);
      chk("timer2_high_reload", eh2, rld2_hi);
      chk("done", {7'h0, hit}, {7'h0, done});
      chk("skip_next", 8'h00, {7'h0, skip_next});
      chk("carry_we", 8'h00, {7'h0, carry_we});
    end
    $display("random instruction test done");
    give_verdict();
  end
endmodule

// File: bench/trli_decode_model.sv
// decode stage model: presents one instruction per issue call
// assumes the bench clock; drives at the falling edge
`timescale 1ns/1ps
module trli_decode_model (
  input wire logic clk,
  output logic exec_en,
  output trli_pkg::trli_opcode_t opcode,
  output trli_pkg::trli_nibble_t acc,
  output trli_pkg::trli_nibble_t opnd
);
  import trli_pkg::*;
  initial begin
    exec_en = 1'b0;
    opcode = 10'h000;
    acc = 4'h0;
    opnd = 4'h0;
  end
  // fresh values every cycle, so a stale field never looks valid
  task automatic issue(input logic e, input logic [9:0] op,
    input logic [3:0] a, input logic [3:0] b);
    @(negedge clk);
    exec_en = e;
    opcode = op;
    acc = a;
    opnd = b;
  endtask
endmodule

// File: pkg/trli_defines.svh
// opcode and reset value constants for the timer load instruction group
// assumes a 10-bit opcode and 4-bit accumulator and operand registers
`ifndef TRLI_DEFINES_SVH
`define TRLI_DEFINES_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define TRLI_OP_LOAD_T1_LOW 10'h230
`define TRLI_OP_LOAD_T1_HIGH 10'h292
`define TRLI_OP_COPY_T1 10'h2A7
`define TRLI_OP_LOAD_T2_LOW 10'h231
`define TRLI_OP_LOAD_T2_HIGH 10'h294

// ----------------------------------------
// reset values
// ----------------------------------------
`define TRLI_REG_RST 8'h00

`endif

// File: pkg/trli_pkg.sv
// types shared by the timer load instruction group
// assumes nothing beyond a SystemVerilog compiler
package trli_pkg;
  typedef logic [9:0] trli_opcode_t;
  typedef logic [3:0] trli_nibble_t;
  typedef logic [7:0] trli_byte_t;
  typedef enum logic [5:0] {
    TRLI_NONE = 6'b000001,
    TRLI_T1_LOW = 6'b000010,
    TRLI_T1_HIGH = 6'b000100,
    TRLI_T1_COPY = 6'b001000,
    TRLI_T2_LOW = 6'b010000,
    TRLI_T2_HIGH = 6'b100000
  } trli_op_e;
endpackage

// File: rtl/trli_reg8.sv
// one 8-bit register with separate nibble write enables
// assumes a single clock and asynchronous active-high reset
`timescale 1ns/1ps
`include "trli_defines.svh"
module trli_reg8 (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_hi,
  input wire logic wr_lo,
  input wire trli_pkg::trli_byte_t wdata,
  output trli_pkg::trli_byte_t rdata
);
  import trli_pkg::*;
  trli_byte_t val_d;
  trli_byte_t val_q;

  always_comb begin
    val_d = val_q;
    if (wr_hi) begin
      val_d[7:4] = wdata[7:4];
    end
    if (wr_lo) begin
      val_d[3:0] = wdata[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      val_q <= `TRLI_REG_RST;
    end else begin
      val_q <= val_d;
    end
  end

  assign rdata = val_q;
endmodule

// File: rtl/trli_top.sv
// execution logic for the timer and reload load instructions
// assumes decode presents opcode with exec_en for one cycle per instruction
// Notes on behaviour
// - load timer1 and low reload: operand register to bits 7..4 of both
// - same opcode: accumulator to bits 3..0 of both, one cycle
// - load timer1 high reload from operand and accumulator; timer1 kept
// - copy all eight low reload bits into timer1 in one cycle
// - load timer2 and low reload: operand high nibble, accumulator low
// - load timer2 high reload from operand and accumulator; timer2 kept
`timescale 1ns/1ps
`include "trli_defines.svh"
module trli_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic exec_en,
  input wire trli_pkg::trli_opcode_t opcode,
  input wire trli_pkg::trli_nibble_t acc,
  input wire trli_pkg::trli_nibble_t opnd,
  output trli_pkg::trli_byte_t timer1,
  output trli_pkg::trli_byte_t timer2,
  output trli_pkg::trli_byte_t timer1_low_reload,
  output trli_pkg::trli_byte_t timer1_high_reload,
  output trli_pkg::trli_byte_t timer2_low_reload,
  output trli_pkg::trli_byte_t timer2_high_reload,
  output logic done,
  output logic skip_next,
  output logic carry_we
);
  import trli_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic trli_op_e decode(input trli_opcode_t op);
    case (op)
      `TRLI_OP_LOAD_T1_LOW: decode = TRLI_T1_LOW;
      `TRLI_OP_LOAD_T1_HIGH: decode = TRLI_T1_HIGH;
      `TRLI_OP_COPY_T1: decode = TRLI_T1_COPY;
      `TRLI_OP_LOAD_T2_LOW: decode = TRLI_T2_LOW;
      `TRLI_OP_LOAD_T2_HIGH: decode = TRLI_T2_HIGH;
      default: decode = TRLI_NONE;
    endcase
  endfunction

  trli_op_e op;
  trli_byte_t ab;
  trli_byte_t t1_d, t1_q, t2_d, t2_q;
  logic done_d, done_q;

  assign op = exec_en ? decode(opcode) : TRLI_NONE;
  assign ab = {opnd, acc};

  // ----------------------------------------
  // reload registers
  // ----------------------------------------
  logic w1l, w1h, w2l, w2h;
  assign w1l = (op == TRLI_T1_LOW);
  assign w1h = (op == TRLI_T1_HIGH);
  assign w2l = (op == TRLI_T2_LOW);
  assign w2h = (op == TRLI_T2_HIGH);

  // both nibbles written together: every load of this group moves a byte
  trli_reg8 u_rel1_lo (
    .clk(clk),
    .rst(rst),
    .wr_hi(w1l),
    .wr_lo(w1l),
    .wdata(ab),
    .rdata(timer1_low_reload)
  );
  trli_reg8 u_rel1_hi (
    .clk(clk),
    .rst(rst),
    .wr_hi(w1h),
    .wr_lo(w1h),
    .wdata(ab),
    .rdata(timer1_high_reload)
  );
  trli_reg8 u_rel2_lo (
    .clk(clk),
    .rst(rst),
    .wr_hi(w2l),
    .wr_lo(w2l),
    .wdata(ab),
    .rdata(timer2_low_reload)
  );
  trli_reg8 u_rel2_hi (
    .clk(clk),
    .rst(rst),
    .wr_hi(w2h),
    .wr_lo(w2h),
    .wdata(ab),
    .rdata(timer2_high_reload)
  );

  // ----------------------------------------
  // timers
  // ----------------------------------------
  always_comb begin
    t1_d = t1_q;
    t2_d = t2_q;
    done_d = 1'b0;
    case (op)
      TRLI_T1_LOW: begin
        t1_d = ab;
      end
      TRLI_T1_COPY: begin
        t1_d = timer1_low_reload;
      end
      TRLI_T2_LOW: begin
        t2_d = ab;
      end
      default: begin
        t1_d = t1_q;
      end
    endcase
    // high reload loads leave timers as they are
    if (op != TRLI_NONE) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t1_q <= `TRLI_REG_RST;
      t2_q <= `TRLI_REG_RST;
      done_q <= 1'b0;
    end else begin
      t1_q <= t1_d;
      t2_q <= t2_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign timer1 = t1_q;
  assign timer2 = t2_q;
  assign done = done_q;

  // ----------------------------------------
  // flag side effects
  // ----------------------------------------
  // this group never writes carry nor skips; held low from flops
  // kept as ports so the core can merge them with other groups
  logic zero_d;
  logic zero_q;
  always_comb begin
    zero_d = 1'h0;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_q <= 1'h0;
    end else begin
      zero_q <= zero_d;
    end
  end
  assign skip_next = zero_q;
  assign carry_we = zero_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // outputs are registered, so every effect is looked at one edge later
  t1_low_load_a: assert property (
    w1l |=> timer1 == $past(ab) && timer1_low_reload == $past(ab))
    else $error("timer1 and low reload byte load");
  t1_high_nib_a: assert property (
    w1l |=> timer1[7:4] == $past(opnd)
    && timer1_low_reload[7:4] == $past(opnd))
    else $error("timer1 upper nibble load");
  t1_nib_a: assert property (
    w1l |=> timer1[3:0] == $past(acc)
    && timer1_low_reload[3:0] == $past(acc))
    else $error("timer1 lower nibble load");
  rel1_high_a: assert property (
    w1h |=> timer1_high_reload == $past(ab) && $stable(timer1))
    else $error("timer1 high reload load");
  rel1_hold_a: assert property (
    !w1h |=> $stable(timer1_high_reload))
    else $error("timer1 high reload changed");
  t1_kept_a: assert property (
    !(w1l || op == TRLI_T1_COPY) |=> $stable(timer1))
    else $error("timer1 changed without load");
  t1_copy_a: assert property (
    op == TRLI_T1_COPY |=> timer1 == $past(timer1_low_reload))
    else $error("copy of low reload into timer1");
  rel1_low_hold_a: assert property (
    !w1l |=> $stable(timer1_low_reload))
    else $error("timer1 low reload changed");
  t2_low_load_a: assert property (
    w2l |=> timer2 == $past(ab) && timer2_low_reload == $past(ab))
    else $error("timer2 and low reload byte load");
  t2_nib_a: assert property (
    w2l |=> timer2[7:4] == $past(opnd) && timer2[3:0] == $past(acc))
    else $error("timer2 nibble load");
  rel2_low_hold_a: assert property (
    !w2l |=> $stable(timer2_low_reload))
    else $error("timer2 low reload changed");
  rel2_high_a: assert property (
    w2h |=> timer2_high_reload == $past(ab) && $stable(timer2))
    else $error("timer2 high reload load");
  rel2_high_hold_a: assert property (
    !w2h |=> $stable(timer2_high_reload))
    else $error("timer2 high reload changed");
  t2_kept_a: assert property (
    !w2l |=> $stable(timer2))
    else $error("timer2 changed without load");
  one_cycle_a: assert property (
    (op != TRLI_NONE) |=> done && !skip_next && !carry_we)
    else $error("one cycle completion");
  idle_keep_a: assert property (
    (op == TRLI_NONE) |=> !done && $stable(timer1) && $stable(timer2))
    else $error("idle cycle changed state");

  c_t1_low_c: cover property (w1l);
  c_copy_c: cover property (w1l ##1 op == TRLI_T1_COPY);
  c_t1_high_c: cover property (w1h);
  c_t2_low_c: cover property (w2l ##1 w2h);
  c_t2_high_c: cover property (w2h);
endmodule
